// file: hdl/tkc_touch_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

//
// Contract
// - timeout straps: low/high 10s, high/low 60s, both high toggle, both low none
// - a detection outlasting the timeout recalibrates that key alone
// - toggle mode: each confirmed touch flips that key's output
// - toggle mode uses a fixed ten second stuck-key timeout
// - toggle mode: timeout and recalibration keep the stored toggle state
// - toggle state flips only on rising detection, never on release
// - sync pulses honoured only in slow mode; unused sync held low outside
// - all four channels sample in one common burst
// - slow mode: sync pulse wakes from sleep for one burst, then sleep again unless a detection is pending
// - slow mode: without sync, the own timer wakes after about 90 ms
// - sync only shortens the interval; the sleep timer still bounds it
// - slow mode timeouts are counted in burst intervals
// - with sync present, counts assume a 55 Hz burst rate
// - fast mode: spread pin high for one burst, clamped low at its end
// - any miss among six successive samples discards a pending detection
// - slow mode: acquisition oscillator stopped between bursts
// - fast mode timeouts are counted in burst intervals too, one per 4 ms burst
// - detection at 12 counts over reference, release 2 counts lower
// - straps read at power-up and every 10 s idle; 25 reads must agree
// - reset low at least 10 us then released recalibrates every channel
module tkc_touch_ctrl
  import tkc_pkg::*;
#(
  parameter int NK = NCH,
  parameter int SW = SIG_W,
  parameter int unsigned BURST_CYC = BURST_MS * CYC_PER_MS,
  parameter int unsigned SLEEP_CYC = SLEEP_MS * CYC_PER_MS,
  parameter int unsigned REREAD_CYC = REREAD_S * 1000 * CYC_PER_MS
)
(
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // option straps
  input wire logic speed_strap_i,
  input wire logic timeout_strap_a_i,
  input wire logic timeout_strap_b_i,
  // sync / spread pin
  input wire logic sync_i,
  output logic ss_o,
  output logic ss_oe_o,
  // acquisition front end
  input wire logic [NK-1:0][SW-1:0] signal_i,
  output logic burst_o,
  output logic osc_run_o,
  output logic sample_stb_o,
  // key outputs
  output logic [NK-1:0] key_o,
  output logic [NK-1:0] det_o,
  output logic [NK-1:0] recal_o,
  // status
  output tkc_opts_t opts_o,
  output logic sync_seen_o
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  tkc_state_t state_q;
  tkc_state_t state_d;
  logic [CYC_W-1:0] cyc_q;
  logic [CYC_W-1:0] reread_q;
  logic sync_q;
  logic sync_seen_q;
  logic ss_q;
  logic ss_oe_q;
  logic osc_q;
  logic burst_q;
  logic stb_q;
  logic start_q;

  tkc_opts_t opts_w;
  logic valid_w;
  logic busy_w;
  logic [NK-1:0] key_w;
  logic [NK-1:0] det_w;
  logic [NK-1:0] pend_w;
  logic [NK-1:0] recal_w;

  ////////////////////////////////////////////////////////////////////////////
  // strap reader
  tkc_strap_reader u_straps (
    .clk_i (clk_i),
    .resetn_i (resetn_i),
    .ce_i (ce_i),
    .start_i (start_q),
    .speed_strap_i (speed_strap_i),
    .timeout_strap_a_i (timeout_strap_a_i),
    .timeout_strap_b_i (timeout_strap_b_i),
    .opts_o (opts_w),
    .valid_o (valid_w),
    .busy_o (busy_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // event decode
  // pin is taken as synchronous, so a plain previous-value edge is enough
  wire logic sync_rise_w = sync_i && !sync_q;
  // fast mode ignores the pin: it is our own spread output there
  wire logic sync_wake_w = sync_rise_w && !opts_w.fast;
  wire logic burst_end_w = (state_q == ST_BURST) && (cyc_q == CYC_W'(BURST_CYC - 1));
  wire logic sleep_end_w = (state_q == ST_SLEEP) && (cyc_q == CYC_W'(SLEEP_CYC - 1));
  wire logic any_det_w = |det_w;
  wire logic any_pend_w = |pend_w;
  // a pending detection skips sleep so six samples come quickly
  wire logic no_sleep_w = opts_w.fast || any_pend_w;
  wire logic reread_end_w = (reread_q == CYC_W'(REREAD_CYC - 1));
  wire logic start_d = (!valid_w && !busy_w) || (reread_end_w && !any_det_w);

  // stuck-key limit in bursts; toggle mode forces the short one
  wire tkc_opts_t tmo_opts_w = '{fast: opts_w.fast, toggle: opts_w.toggle,
                                 tmo_en: opts_w.tmo_en,
                                 tmo_long: opts_w.tmo_long && !opts_w.toggle};
  // counted per burst so burst spacing scales them
  wire logic [TMO_W-1:0] tmo_limit_w = tkc_tmo_bursts(tmo_opts_w, sync_seen_q);

  ////////////////////////////////////////////////////////////////////////////
  // burst sequencer
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_OPTS:
        if (valid_w)
          state_d = ST_BURST;
      ST_BURST:
        if (burst_end_w)
          state_d = no_sleep_w ? ST_BURST : ST_SLEEP;
      ST_SLEEP:
        // sync may only shorten the nap; the timer bounds it
        if (sync_wake_w || sleep_end_w)
          state_d = ST_BURST;
    endcase
  end

  wire logic restart_w = (state_d != state_q) || burst_end_w;
  wire logic [CYC_W-1:0] cyc_d = restart_w ? '0 : cyc_q + 1'b1;
  wire logic seen_d = (state_q == ST_SLEEP && sync_wake_w) ? 1'b1 :
                      (sleep_end_w || opts_w.fast) ? 1'b0 : sync_seen_q;
  wire logic burst_d = (state_d == ST_BURST) && !(burst_end_w && !no_sleep_w);
  // spread drive, fast mode only: high through each burst, low at every burst end
  wire logic ss_d = opts_w.fast && burst_d && !burst_end_w;
  // slow mode stops the acquisition oscillator while asleep
  wire logic osc_d = opts_w.fast || burst_d;
  wire logic [CYC_W-1:0] reread_d = (any_det_w || reread_end_w) ? '0 : reread_q + 1'b1;

  // sequencer registers
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_q <= ST_OPTS;
      cyc_q <= '0;
      reread_q <= '0;
      sync_q <= 1'b0;
      sync_seen_q <= 1'b0;
      ss_q <= 1'b0;
      ss_oe_q <= 1'b0;
      osc_q <= 1'b0;
      burst_q <= 1'b0;
      stb_q <= 1'b0;
      start_q <= 1'b0;
    end
    else if (ce_i)
    begin
      state_q <= state_d;
      cyc_q <= cyc_d;
      reread_q <= reread_d;
      sync_q <= sync_i;
      sync_seen_q <= seen_d;
      ss_q <= ss_d;
      ss_oe_q <= opts_w.fast;
      osc_q <= osc_d;
      burst_q <= burst_d;
      stb_q <= burst_end_w; // one strobe for all channels
      start_q <= start_d && !start_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // key channels, all fed by the same end-of-burst strobe
  for (genvar k = 0; k < NK; k++)
  begin : g_key
    tkc_key_channel #(
      .SW (SW),
      .TW (TMO_W)
    ) u_key (
      .clk_i (clk_i),
      .resetn_i (resetn_i),
      .ce_i (ce_i),
      .sample_stb_i (stb_q),
      .signal_i (signal_i[k]),
      .toggle_i (opts_w.toggle),
      .tmo_en_i (opts_w.tmo_en),
      .tmo_limit_i (tmo_limit_w),
      .key_o (key_w[k]),
      .det_o (det_w[k]),
      .pending_o (pend_w[k]),
      .recal_o (recal_w[k])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign ss_o = ss_q;
  assign ss_oe_o = ss_oe_q;
  assign burst_o = burst_q;
  assign osc_run_o = osc_q;
  assign sample_stb_o = stb_q;
  assign key_o = key_w;
  assign det_o = det_w;
  assign recal_o = recal_w;
  assign opts_o = opts_w;
  assign sync_seen_o = sync_seen_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_ss_clamp_end: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && burst_end_w |=> !ss_q && stb_q)
    else $error("spread pin not clamped at burst end");
  a_ss_in_burst: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ss_q |-> burst_q && ss_oe_q)
    else $error("spread pin driven outside a burst");
  a_sync_fast_ignored: assert property (@(posedge clk_i) disable iff (!resetn_i)
    opts_w.fast |-> !sync_wake_w && state_q != ST_SLEEP)
    else $error("sync acted in fast mode");
  a_sync_wakes: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && state_q == ST_SLEEP && sync_rise_w && !opts_w.fast |=> state_q == ST_BURST && sync_seen_q)
    else $error("sync pulse did not wake the sequencer");
  a_sleep_bound: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state_q == ST_SLEEP |-> cyc_q < CYC_W'(SLEEP_CYC))
    else $error("sleep ran past its timer");
  a_osc_asleep: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $past(ce_i) && state_q == ST_SLEEP && $past(state_q) == ST_SLEEP |-> !osc_q && !burst_q)
    else $error("oscillator running during slow sleep");
  a_toggle_tmo: assert property (@(posedge clk_i) disable iff (!resetn_i)
    opts_w.toggle && !opts_w.fast && !sync_seen_q |-> tmo_limit_w == TMO_W'(TMO_SLOW_SHORT))
    else $error("toggle mode timeout not ten seconds");
  a_sync_tmo: assert property (@(posedge clk_i) disable iff (!resetn_i)
    sync_seen_q && !opts_w.toggle && opts_w.tmo_long |-> tmo_limit_w == TMO_W'(TMO_SYNC_LONG))
    else $error("sync timeout not scaled to 55 Hz");
  a_burst_len: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state_q == ST_BURST |-> cyc_q < CYC_W'(BURST_CYC))
    else $error("burst longer than its length");

endmodule // tkc_touch_ctrl

`default_nettype wire

// file: hdl/tkc_pkg.sv
package tkc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and sizes
  localparam int CLK_MHZ = 100;
  localparam int CYC_PER_MS = CLK_MHZ * 1000;
  localparam int NCH = 4;
  localparam int SIG_W = 16;
  localparam int TMO_W = 16;
  localparam int CYC_W = 32;

  ////////////////////////////////////////////////////////////////////////////
  // detection filter figures
  localparam int THR_COUNTS = 12;
  localparam int HYST_COUNTS = 2;
  localparam int INTEG_LEN = 6;
  localparam int INTEG_W = 3;

  ////////////////////////////////////////////////////////////////////////////
  // strap sampling: 25 reads spread over 250 us, reread every 10 s
  localparam int STRAP_READS = 25;
  localparam int STRAP_WIN_US = 250;
  localparam int STRAP_GAP_CYC = (STRAP_WIN_US * CLK_MHZ) / STRAP_READS;
  localparam int STRAP_GAP_W = $clog2(STRAP_GAP_CYC);
  localparam int STRAP_CNT_W = $clog2(STRAP_READS);
  localparam int REREAD_S = 10;

  ////////////////////////////////////////////////////////////////////////////
  // burst sequencing times
  localparam int BURST_MS = 4;
  localparam int SLEEP_MS = 90;
  localparam int SYNC_HZ = 55;
  localparam int TMO_SHORT_S = 10;
  localparam int TMO_LONG_S = 60;

  // timeout limits in burst intervals
  localparam int TMO_FAST_SHORT = (TMO_SHORT_S * 1000) / BURST_MS;
  localparam int TMO_FAST_LONG = (TMO_LONG_S * 1000) / BURST_MS;
  localparam int TMO_SLOW_SHORT = (TMO_SHORT_S * 1000) / (SLEEP_MS + BURST_MS);
  localparam int TMO_SLOW_LONG = (TMO_LONG_S * 1000) / (SLEEP_MS + BURST_MS);
  localparam int TMO_SYNC_SHORT = TMO_SHORT_S * SYNC_HZ;
  localparam int TMO_SYNC_LONG = TMO_LONG_S * SYNC_HZ;

  ////////////////////////////////////////////////////////////////////////////
  // decoded options
  typedef struct packed {
    logic fast;
    logic toggle;
    logic tmo_en;
    logic tmo_long;
  } tkc_opts_t;

  localparam tkc_opts_t OPTS_RST = tkc_opts_t'(4'h0);

  typedef enum logic [1:0] {ST_OPTS, ST_SLEEP, ST_BURST} tkc_state_t;

  // strap decode: speed low is fast; a/b pick timeout or toggle
  function automatic tkc_opts_t tkc_decode(input logic [2:0] s);
    tkc_opts_t o;
    o.fast = ~s[2];
    o.toggle = s[1] & s[0];
    o.tmo_en = s[1] | s[0];
    o.tmo_long = s[1] & ~s[0];
    return o;
  endfunction

  // stuck-key limit in bursts for the current mode
  function automatic logic [TMO_W-1:0] tkc_tmo_bursts(input tkc_opts_t o, input logic sync_seen);
    logic [TMO_W-1:0] r;
    if (o.fast)
      r = o.tmo_long ? TMO_W'(TMO_FAST_LONG) : TMO_W'(TMO_FAST_SHORT);
    else if (sync_seen)
      r = o.tmo_long ? TMO_W'(TMO_SYNC_LONG) : TMO_W'(TMO_SYNC_SHORT);
    else
      r = o.tmo_long ? TMO_W'(TMO_SLOW_LONG) : TMO_W'(TMO_SLOW_SHORT);
    return r;
  endfunction

endpackage

// file: hdl/tkc_strap_reader.sv
`timescale 1ns/1ps
`default_nettype none

module tkc_strap_reader
  import tkc_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // control
  input wire logic start_i,
  // straps
  input wire logic speed_strap_i,
  input wire logic timeout_strap_a_i,
  input wire logic timeout_strap_b_i,
  // result
  output tkc_opts_t opts_o,
  output logic valid_o,
  output logic busy_o
);

  logic [STRAP_GAP_W-1:0] gap_q;
  logic [STRAP_CNT_W-1:0] cnt_q;
  logic [2:0] first_q;
  logic agree_q;
  tkc_opts_t opts_q;
  logic valid_q;
  logic busy_q;

  ////////////////////////////////////////////////////////////////////////////
  // read strobes and agreement
  wire logic [2:0] now_w = {speed_strap_i, timeout_strap_a_i, timeout_strap_b_i};
  wire logic take_w = busy_q && (gap_q == '0);
  wire logic last_w = take_w && (cnt_q == STRAP_CNT_W'(STRAP_READS - 1));
  wire logic same_w = (cnt_q == '0) || (now_w == first_q);
  wire logic ok_w = agree_q && same_w;
  wire logic gap_end_w = (gap_q == STRAP_GAP_W'(STRAP_GAP_CYC - 1));

  // one disagreeing read spoils the whole set; old options stay in force
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      gap_q <= '0;
      cnt_q <= '0;
      first_q <= 3'h0;
      agree_q <= 1'b0;
      opts_q <= OPTS_RST;
      valid_q <= 1'b0;
      busy_q <= 1'b0;
    end
    else if (ce_i)
    begin
      if (start_i && !busy_q)
      begin
        busy_q <= 1'b1;
        gap_q <= '0;
        cnt_q <= '0;
        agree_q <= 1'b1;
      end
      else if (busy_q)
      begin
        gap_q <= gap_end_w ? '0 : gap_q + 1'b1;
        if (take_w)
        begin
          cnt_q <= cnt_q + 1'b1;
          agree_q <= ok_w;
          if (cnt_q == '0)
            first_q <= now_w;
        end
        if (last_w)
        begin
          busy_q <= 1'b0;
          if (ok_w)
          begin
            opts_q <= tkc_decode(first_q);
            valid_q <= 1'b1;
          end
        end
      end
    end
  end

  assign opts_o = opts_q;
  assign valid_o = valid_q;
  assign busy_o = busy_q;

endmodule // tkc_strap_reader

`default_nettype wire

// file: hdl/tkc_key_channel.sv
`timescale 1ns/1ps
`default_nettype none

module tkc_key_channel
  import tkc_pkg::*;
#(
  parameter int SW = SIG_W,
  parameter int TW = TMO_W
)
(
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // burst result
  input wire logic sample_stb_i,
  input wire logic [SW-1:0] signal_i,
  // mode
  input wire logic toggle_i,
  input wire logic tmo_en_i,
  input wire logic [TW-1:0] tmo_limit_i,
  // outputs
  output logic key_o,
  output logic det_o,
  output logic pending_o,
  output logic recal_o
);

  logic [SW-1:0] ref_q;
  logic cal_q;
  logic [INTEG_W-1:0] integ_q;
  logic det_q;
  logic tog_q;
  logic key_q;
  logic [TW-1:0] on_q;
  logic recal_q;

  ////////////////////////////////////////////////////////////////////////////
  // threshold compare, one extra bit so the sum cannot wrap
  wire logic [SW:0] thr_w = {1'b0, ref_q} + (SW+1)'(THR_COUNTS);
  wire logic [SW:0] rel_w = {1'b0, ref_q} + (SW+1)'(THR_COUNTS - HYST_COUNTS);
  wire logic hit_w = ({1'b0, signal_i} >= thr_w);
  wire logic hold_w = ({1'b0, signal_i} >= rel_w);
  wire logic full_w = (integ_q == INTEG_W'(INTEG_LEN - 1));
  wire logic stuck_w = det_q && tmo_en_i && (on_q >= tmo_limit_i - 1'b1);
  wire logic cal_w = sample_stb_i && (cal_q || stuck_w);
  wire logic run_w = sample_stb_i && !cal_q && !stuck_w;

  // consensus filter: any miss before six hits drops the count
  wire logic [INTEG_W-1:0] integ_d = cal_w ? '0 :
                                     !run_w ? integ_q :
                                     (det_q || !hit_w || full_w) ? '0 : integ_q + 1'b1;
  wire logic det_d = cal_w ? 1'b0 :
                     !run_w ? det_q :
                     det_q ? hold_w : (hit_w && full_w);
  wire logic [TW-1:0] on_d = cal_w ? '0 :
                             !run_w ? on_q :
                             (det_q && hold_w) ? on_q + 1'b1 : '0;
  // flip only on a rising detection; recal leaves the stored state alone
  wire logic tog_d = tog_q ^ (toggle_i && det_d && !det_q);
  wire logic key_d = toggle_i ? tog_d : det_d;

  ////////////////////////////////////////////////////////////////////////////
  // state; reset leaves a calibration pending for the first burst
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ref_q <= '0;
      cal_q <= 1'b1;
      integ_q <= '0;
      det_q <= 1'b0;
      tog_q <= 1'b0;
      key_q <= 1'b0;
      on_q <= '0;
      recal_q <= 1'b0;
    end
    else if (ce_i)
    begin
      if (cal_w)
        ref_q <= signal_i; // only this channel is touched
      cal_q <= cal_q && !sample_stb_i;
      integ_q <= integ_d;
      det_q <= det_d;
      tog_q <= tog_d;
      key_q <= key_d;
      on_q <= on_d;
      recal_q <= cal_w;
    end
  end

  assign key_o = key_q;
  assign det_o = det_q;
  assign pending_o = (integ_q != '0);
  assign recal_o = recal_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_integ_six: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(det_q) |-> $past(integ_q) == INTEG_W'(INTEG_LEN - 1) && $past(sample_stb_i))
    else $error("detection confirmed without six hits");
  a_toggle_cause: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $changed(tog_q) |-> $rose(det_q))
    else $error("toggle state changed without a rising detection");
  a_toggle_flip: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(det_q) && $past(toggle_i) |-> tog_q != $past(tog_q))
    else $error("toggle state missed a touch");
  a_level_out: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $past(ce_i) && !$past(toggle_i) |-> key_q == det_q)
    else $error("level output differs from detection");
  a_stuck_recal: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && stuck_w && sample_stb_i |=> !det_q && recal_q && on_q == '0)
    else $error("stuck key not recalibrated");

endmodule // tkc_key_channel

`default_nettype wire

// file: verification/tkc_sync_src.sv
`timescale 1ns/1ps
`default_nettype none
module tkc_sync_src #(
  parameter int PERIOD = 70
)
(
  // clock and control
  input wire logic clk_i,
  input wire logic en_i,
  // sync pin drive
  output logic sync_o
);
  int cnt_q;
  // two-cycle pulse per period, low when unused
  // period under the sleep time: sync only shortens it
  always_ff @(posedge clk_i)
  begin
    cnt_q <= (!en_i || cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
    sync_o <= en_i && cnt_q < 2;
  end
endmodule // tkc_sync_src
`default_nettype wire

// file: verification/touch_key_option_sync_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module touch_key_option_sync_control_tb_top;
  import tkc_pkg::*;
  localparam int SC = 100;
  localparam int BASE = 256;
  logic clk_i, resetn_i, spd, ta, tb, sync_i, sync_en, run_chk, stb_seen, exp_fast, exp_tog, cal_m;
  logic ss_o, ss_oe_o, burst_o, osc_run_o, sample_stb_o, sync_seen_o;
  logic [NCH-1:0][SIG_W-1:0] signal_i, s;
  logic [NCH-1:0] key_o, det_o, recal_o, det_m, tog_m, touch;
  logic [31:0] lfsr;
  tkc_opts_t opts_o;
  logic [7:0] exp_q[$];
  int bad_count, comparisons, cyc, gap;
  int ref_v[NCH], integ[NCH], ontime[NCH];

  tkc_touch_ctrl #(.BURST_CYC(20), .SLEEP_CYC(SC), .REREAD_CYC(500000)) i_dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1),
    .speed_strap_i(spd), .timeout_strap_a_i(ta), .timeout_strap_b_i(tb),
    .sync_i(sync_i), .ss_o(ss_o), .ss_oe_o(ss_oe_o), .signal_i(signal_i),
    .burst_o(burst_o), .osc_run_o(osc_run_o), .sample_stb_o(sample_stb_o),
    .key_o(key_o), .det_o(det_o), .recal_o(recal_o), .opts_o(opts_o), .sync_seen_o(sync_seen_o));
  tkc_sync_src i_sync (.clk_i(clk_i), .en_i(sync_en), .sync_o(sync_i));

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard; the ceiling covers two strap reads plus traffic
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 100000)
    begin
      bad_count++;
      end_sim();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    if (bad_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  function automatic logic [31:0] nxt(input logic [31:0] v);
    return v[0] ? (v >> 1) ^ 32'hA3000000 : v >> 1;
  endfunction

  // drive one sample set, wait for its strobe, note the expected outputs
  task automatic step(input logic [NCH-1:0][SIG_W-1:0] sig);
    logic [7:0] e;
    int lim;
    lim = exp_fast ? TMO_FAST_SHORT : TMO_SLOW_SHORT;
    @(negedge clk_i);
    signal_i = sig;
    while (sample_stb_o !== 1'b1)
      @(negedge clk_i);
    for (int k = 0; k < NCH; k++)
    begin
      if (cal_m)
        ref_v[k] = sig[k];
      else if (!det_m[k])
      begin
        integ[k] = (sig[k] >= ref_v[k] + THR_COUNTS) ? integ[k] + 1 : 0;
        if (integ[k] == INTEG_LEN)
        begin
          det_m[k] = 1'b1;
          ontime[k] = 0;
          tog_m[k] = ~tog_m[k];
        end
      end
      else if (sig[k] < ref_v[k] + THR_COUNTS - HYST_COUNTS)
      begin
        det_m[k] = 1'b0;
        integ[k] = 0;
      end
      else if (ontime[k] == lim - 1)
      begin
        ref_v[k] = sig[k];
        det_m[k] = 1'b0;
        integ[k] = 0;
      end
      else
        ontime[k]++;
      e[k] = exp_tog ? tog_m[k] : det_m[k];
      e[k+4] = det_m[k];
    end
    cal_m = 1'b0;
    exp_q.push_back(e);
  endtask

  // reset with new straps; the first strobe only calibrates
  task automatic start(input logic sp, input logic a, input logic b);
    repeat (2) @(negedge clk_i);
    resetn_i = 1'b0;
    run_chk = 1'b0;
    {spd, ta, tb} = {sp, a, b};
    exp_fast = !sp;
    exp_tog = a & b;
    {cal_m, det_m, tog_m, touch} = {1'b1, 12'h000};
    for (int k = 0; k < NCH; k++)
      integ[k] = 0;
    repeat (3) @(negedge clk_i);
    resetn_i = 1'b1;
    step({NCH{SIG_W'(BASE)}});
    check(opts_o, {!sp, a & b, a | b, a & !b});
    run_chk = 1'b1;
  endtask

  // random touches; 10 and 11 counts over reference sit in the hysteresis band
  task automatic traffic(input int n);
    repeat (n)
    begin
      for (int k = 0; k < NCH; k++)
      begin
        lfsr = nxt(lfsr);
        if (lfsr[2:0] == 3'h0)
          touch[k] = ~touch[k];
        s[k] = SIG_W'(BASE + (touch[k] ? 10 + lfsr[6:4] : lfsr[6:4]));
      end
      step(s);
    end
  endtask

  task automatic meas_gap;
    gap = 0;
    while (burst_o !== 1'b1)
      @(negedge clk_i);
    while (burst_o === 1'b1)
      @(negedge clk_i);
    while (burst_o !== 1'b1 && gap < 1000)
    begin
      @(negedge clk_i);
      gap++;
    end
    @(negedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // output watcher: oldest note against each strobe's result, plus pin levels
  always @(negedge clk_i)
  begin
    if (stb_seen && exp_q.size() > 0)
      check({det_o, key_o}, exp_q.pop_front());
    if (run_chk && exp_fast)
      check({burst_o, osc_run_o, ss_oe_o, ss_o}, {3'h7, !sample_stb_o});
    if (run_chk && !exp_fast && !burst_o && !sample_stb_o && !stb_seen)
      check({osc_run_o, ss_oe_o}, 2'h0);
    stb_seen = sample_stb_o;
  end

  // main sequence: fast level mode, then slow toggle mode with sync
  initial
  begin
    {resetn_i, spd, ta, tb, sync_en, run_chk, stb_seen} = 7'h00;
    {exp_fast, exp_tog, cal_m, det_m, tog_m, touch} = 15'h0;
    lfsr = 32'h23F1;
    signal_i = '0;
    start(1'b0, 1'b0, 1'b1);
    traffic(200);
    start(1'b1, 1'b1, 1'b1);
    traffic(100);
    repeat (3) step({NCH{SIG_W'(BASE)}});
    s = {NCH{SIG_W'(BASE)}};
    s[0] = SIG_W'(BASE + 15);
    repeat (TMO_SLOW_SHORT + 12) step(s);
    repeat (3) step({NCH{SIG_W'(BASE)}});
    sync_en = 1'b1;
    meas_gap();
    meas_gap();
    check(gap < SC && sync_seen_o === 1'b1, 1'b1);
    sync_en = 1'b0;
    meas_gap();
    meas_gap();
    check(gap >= SC - 1 && gap <= SC + 2 && sync_seen_o === 1'b0, 1'b1);
    end_sim();
  end
endmodule // touch_key_option_sync_control_tb_top
`default_nettype wire
